// file: logic/efc_controller.sv
// Embedded flash command controller: register port, checks, sequencing, array model.
// Assumes single-cycle register strobes from the CPU; cpu_stall must idle the CPU.
// How it works
// - Hold the processor stalled while a write or erase command runs.
// - Main array is 32K bytes in 1024-byte sectors.
// - Separate 256-byte information sector with its own read and write.
// - After byte write, read back and clear verify flag on mismatch.
// - Verify flag returns to one when a new command starts.
// - Failure flag set on failed command, kept across reads, cleared on new command.
// - Out-of-range or protected addresses flag failure.
// - Timeout counts on system clock over 256 over scaler plus one.
// - Timeout select picks write and erase cycle counts from fixed tables.
// - Five-bit command code one-hot decode of five commands.
// - Unknown command codes are not run and set failure.
// - Address from concatenated high and low address registers, data through data register.
// - Erase picks sector from high address bits and clears it.
// - Main-array erase and write addresses checked against protection bounds first.
// - Information writes allowed only at offsets 0x40 to 0xFF.
// - Reserved fuse area is readable only, never written or erased.
// - Command register resets to 0x80.
// - Protection bounds count in 256-byte granules.
// - Low bound resets to all ones.
// - High bound resets to zero.
`default_nettype none
module efc_controller #(
    parameter int MAIN_BYTES   = efc_pkg::MAIN_BYTES,
    parameter int SECTOR_BYTES = efc_pkg::SECTOR_BYTES,
    parameter int INFO_BYTES   = efc_pkg::INFO_BYTES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             cpu_stall
);
    typedef enum logic [1:0] {
        EFC_IDLE   = 2'b00,
        EFC_TIMED  = 2'b01,
        EFC_VERIFY = 2'b10
    } efc_state_t;

    efc_state_t  state;
    logic [2:0]  timeout_select;
    logic [4:0]  command_code;
    logic        write_verify_ok;
    logic        fail;
    logic [7:0]  flash_data_byte;
    logic [7:0]  address_top_byte;
    logic [7:0]  address_low_byte;
    logic [7:0]  addr_high;
    logic [7:0]  program_clock_scaler;
    logic [7:0]  protect_low_bound;
    logic [7:0]  protect_high_bound;
    logic [13:0] tick_count;
    logic [13:0] target;
    logic        is_erase;
    logic [15:0] op_addr;
    logic [7:0]  op_data;
    logic        tick;
    logic [7:0]  main_mem [MAIN_BYTES];
    logic [7:0]  info_mem [INFO_BYTES];

    logic        cmd_wr;
    logic [15:0] flash_addr;
    logic        out_of_range;
    logic        protected_hit;
    logic        info_reserved;
    logic        cmd_bad;
    logic [4:0]  wcode;

    function automatic logic is_protected(input logic [15:0] a, input logic [7:0] lo,
                                          input logic [7:0] hi);
        is_protected = (a[15:8] < lo) || (a[15:8] > hi);
    endfunction

    assign cmd_wr     = reg_wr && (reg_addr == efc_pkg::CMD_REG_ADDR) && (state == EFC_IDLE);
    assign wcode      = reg_wdata[4:0];
    assign flash_addr = {addr_high, address_low_byte};
    assign target     = is_erase ? efc_pkg::ERASE_CYCLES[timeout_select] :
                        efc_pkg::WRITE_CYCLES[timeout_select];

    always_comb begin
        out_of_range  = 1'b0;
        protected_hit = 1'b0;
        info_reserved = 1'b0;
        cmd_bad       = 1'b0;
        unique case (wcode)
            efc_pkg::CMD_MAIN_READ: begin
                out_of_range = flash_addr >= 16'(MAIN_BYTES);
            end
            efc_pkg::CMD_MAIN_ERASE, efc_pkg::CMD_MAIN_WRITE: begin
                out_of_range  = flash_addr >= 16'(MAIN_BYTES);
                protected_hit = is_protected(flash_addr, protect_low_bound,
                                             protect_high_bound);
            end
            efc_pkg::CMD_INFO_READ: begin
                out_of_range = flash_addr >= 16'(INFO_BYTES);
            end
            efc_pkg::CMD_INFO_WRITE: begin
                out_of_range  = flash_addr >= 16'(INFO_BYTES);
                info_reserved = address_low_byte < efc_pkg::INFO_WRITE_FIRST;
            end
            default: begin
                cmd_bad = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            timeout_select       <= efc_pkg::CMD_RESET[efc_pkg::CYC_MSB:efc_pkg::CYC_LSB];
            flash_data_byte      <= efc_pkg::ZERO_RESET;
            address_top_byte     <= efc_pkg::ZERO_RESET;
            address_low_byte     <= efc_pkg::ZERO_RESET;
            addr_high            <= efc_pkg::ZERO_RESET;
            program_clock_scaler <= efc_pkg::SCALE_RESET;
            protect_low_bound    <= efc_pkg::PLOW_RESET;
            protect_high_bound   <= efc_pkg::PHIGH_RESET;
        end else if (reg_wr && state == EFC_IDLE) begin
            unique case (reg_addr)
                efc_pkg::CMD_REG_ADDR: begin
                    timeout_select <= reg_wdata[efc_pkg::CYC_MSB:efc_pkg::CYC_LSB];
                end
                efc_pkg::ADDRM_REG_ADDR: address_top_byte <= reg_wdata;
                efc_pkg::ADDRL_REG_ADDR: address_low_byte <= reg_wdata;
                efc_pkg::ADDRH_REG_ADDR: addr_high <= reg_wdata;
                efc_pkg::SCALE_REG_ADDR: program_clock_scaler <= reg_wdata;
                efc_pkg::PLOW_REG_ADDR:  protect_low_bound <= reg_wdata;
                efc_pkg::PHIGH_REG_ADDR: protect_high_bound <= reg_wdata;
                efc_pkg::DATA_REG_ADDR:  flash_data_byte <= reg_wdata;
                default: begin
                end
            endcase
            // read data returned through data register
            if (cmd_wr && !(out_of_range || cmd_bad)) begin
                if (wcode == efc_pkg::CMD_MAIN_READ) begin
                    flash_data_byte <= main_mem[flash_addr[14:0]];
                end else if (wcode == efc_pkg::CMD_INFO_READ) begin
                    flash_data_byte <= info_mem[flash_addr[7:0]];
                end
            end
        end
    end

    // Array content is held in flip-flops; a real macro would replace this
    always_ff @(posedge core_clk) begin
        if (state == EFC_TIMED && tick && tick_count + 14'd1 >= target) begin
            if (is_erase) begin
                // whole sector cleared from high bits
                for (int i = 0; i < SECTOR_BYTES; i++) begin
                    main_mem[{op_addr[14:10], 10'(i)}] <= 8'hFF;
                end
            end else if (command_code == efc_pkg::CMD_INFO_WRITE) begin
                info_mem[op_addr[7:0]] <= op_data;
            end else begin
                main_mem[op_addr[14:0]] <= op_data;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state        <= EFC_IDLE;
            command_code <= 5'h00;
            op_addr      <= 16'h0000;
            op_data      <= 8'h00;
            is_erase     <= 1'b0;
            tick_count   <= 14'h0000;
        end else begin
            unique case (state)
                EFC_IDLE: begin
                    if (cmd_wr) begin
                        command_code <= wcode;
                        op_addr      <= flash_addr;
                        op_data      <= flash_data_byte;
                        is_erase     <= wcode == efc_pkg::CMD_MAIN_ERASE;
                        tick_count   <= 14'h0000;
                        if (!(out_of_range || protected_hit || info_reserved || cmd_bad) &&
                            (wcode == efc_pkg::CMD_MAIN_ERASE ||
                             wcode == efc_pkg::CMD_MAIN_WRITE ||
                             wcode == efc_pkg::CMD_INFO_WRITE)) begin
                            state <= EFC_TIMED;
                        end
                    end
                end
                EFC_TIMED: begin
                    if (tick) begin
                        tick_count <= tick_count + 14'd1;
                        if (tick_count + 14'd1 >= target) begin
                            state <= is_erase ? EFC_IDLE : EFC_VERIFY;
                        end
                    end
                end
                EFC_VERIFY: begin
                    state <= EFC_IDLE;
                end
                default: begin
                    state <= EFC_IDLE;
                end
            endcase
        end
    end

    // failure flag kept until new command
    // verify flag restored on command start
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fail            <= efc_pkg::CMD_RESET[efc_pkg::FAIL_BIT];
            write_verify_ok <= efc_pkg::CMD_RESET[efc_pkg::VERIFY_BIT];
        end else if (cmd_wr) begin
            fail            <= out_of_range || protected_hit || info_reserved || cmd_bad;
            write_verify_ok <= 1'b1;
        end else if (state == EFC_VERIFY) begin
            if (command_code == efc_pkg::CMD_INFO_WRITE) begin
                write_verify_ok <= info_mem[op_addr[7:0]] == op_data;
            end else begin
                write_verify_ok <= main_mem[op_addr[14:0]] == op_data;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_stall <= 1'b0;
        end else begin
            cpu_stall <= (state == EFC_IDLE) ? cmd_wr &&
                         !(out_of_range || protected_hit || info_reserved || cmd_bad) &&
                         (wcode == efc_pkg::CMD_MAIN_ERASE ||
                          wcode == efc_pkg::CMD_MAIN_WRITE ||
                          wcode == efc_pkg::CMD_INFO_WRITE) :
                         !(state == EFC_VERIFY);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                efc_pkg::CMD_REG_ADDR:   reg_rdata <= {write_verify_ok, 1'b0, fail, command_code};
                efc_pkg::DATA_REG_ADDR:  reg_rdata <= flash_data_byte;
                efc_pkg::ADDRH_REG_ADDR: reg_rdata <= addr_high;
                efc_pkg::ADDRL_REG_ADDR: reg_rdata <= address_low_byte;
                efc_pkg::ADDRM_REG_ADDR: reg_rdata <= address_top_byte;
                efc_pkg::SCALE_REG_ADDR: reg_rdata <= program_clock_scaler;
                efc_pkg::PLOW_REG_ADDR:  reg_rdata <= protect_low_bound;
                efc_pkg::PHIGH_REG_ADDR: reg_rdata <= protect_high_bound;
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

    efc_time_base #(
        .PRESCALE (efc_pkg::PRESCALE)
    ) u_time_base (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (state == EFC_IDLE),
        .scaler   (program_clock_scaler),
        .tick     (tick)
    );

    a_fail_on_bad: assert property (@(posedge core_clk) disable iff (rst)
        cmd_wr && cmd_bad |=> fail) else $error("bad code did not fail");
    a_protect_no_run: assert property (@(posedge core_clk) disable iff (rst)
        cmd_wr && protected_hit |=> state == EFC_IDLE && fail) else $error("protected ran");
    a_info_guard: assert property (@(posedge core_clk) disable iff (rst)
        cmd_wr && wcode == efc_pkg::CMD_INFO_WRITE && info_reserved |=> fail)
        else $error("reserved info write ran");
    a_verify_restore: assert property (@(posedge core_clk) disable iff (rst)
        cmd_wr |=> write_verify_ok) else $error("verify not restored");
    a_fail_holds: assert property (@(posedge core_clk) disable iff (rst)
        !cmd_wr |=> fail == $past(fail)) else $error("fail changed without command");
    a_stall_busy: assert property (@(posedge core_clk) disable iff (rst)
        state == EFC_TIMED |-> cpu_stall) else $error("no stall while busy");
    a_end_count: assert property (@(posedge core_clk) disable iff (rst)
        state == EFC_TIMED |-> tick_count < target) else $error("count overran");
    a_range_fail: assert property (@(posedge core_clk) disable iff (rst)
        cmd_wr && out_of_range |=> fail && state == EFC_IDLE) else $error("range miss");
    c_write_run: cover property (@(posedge core_clk) state == EFC_VERIFY);
    c_erase_run: cover property (@(posedge core_clk) state == EFC_TIMED && is_erase);
    c_fail_seen: cover property (@(posedge core_clk) cmd_wr && protected_hit);
endmodule
`default_nettype wire

// file: logic/efc_pkg.sv
// Package for the embedded flash command controller: register map, fields, timing.
// Assumes a byte-wide special-register port from the CPU side.
`default_nettype none
package efc_pkg;
    localparam logic [15:0] CMD_REG_ADDR   = 16'hA020;
    localparam logic [15:0] DATA_REG_ADDR  = 16'hA021;
    localparam logic [15:0] ADDRH_REG_ADDR = 16'hA022;
    localparam logic [15:0] ADDRL_REG_ADDR = 16'hA023;
    localparam logic [15:0] SCALE_REG_ADDR = 16'hA024;
    localparam logic [15:0] PLOW_REG_ADDR  = 16'hA025;
    localparam logic [15:0] PHIGH_REG_ADDR = 16'hA026;
    localparam logic [15:0] ADDRM_REG_ADDR = 16'hA012;

    localparam logic [7:0] CMD_RESET   = 8'h80;
    localparam logic [7:0] SCALE_RESET = 8'h25;
    localparam logic [7:0] PLOW_RESET  = 8'hFF;
    localparam logic [7:0] PHIGH_RESET = 8'h00;
    localparam logic [7:0] ZERO_RESET  = 8'h00;

    localparam int VERIFY_BIT = 7;
    localparam int FAIL_BIT   = 5;
    localparam int CYC_MSB    = 7;
    localparam int CYC_LSB    = 5;

    localparam logic [4:0] CMD_MAIN_READ  = 5'h10;
    localparam logic [4:0] CMD_MAIN_ERASE = 5'h08;
    localparam logic [4:0] CMD_MAIN_WRITE = 5'h04;
    localparam logic [4:0] CMD_INFO_READ  = 5'h02;
    localparam logic [4:0] CMD_INFO_WRITE = 5'h01;

    localparam int MAIN_BYTES   = 32768;
    localparam int SECTOR_BYTES = 1024;
    localparam int INFO_BYTES   = 256;
    localparam logic [7:0] INFO_WRITE_FIRST = 8'h40;
    localparam int PRESCALE     = 256;

    localparam logic [13:0] WRITE_CYCLES [8] = '{14'd55, 14'd60, 14'd65, 14'd69,
                                                 14'd75, 14'd80, 14'd85, 14'd89};
    localparam logic [13:0] ERASE_CYCLES [8] = '{14'd5435, 14'd5953, 14'd6452, 14'd6897,
                                                 14'd7408, 14'd7906, 14'd8404, 14'd8889};
endpackage
`default_nettype wire

// file: logic/efc_time_base.sv
// Timeout time base: one tick per 256*(scaler+1) system clocks.
// Assumes scaler is stable while a command runs.
`default_nettype none
module efc_time_base #(
    parameter int PRESCALE = 256
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic [7:0] scaler,
    output logic            tick
);
    logic [7:0] pre_cnt;
    logic [7:0] scale_cnt;

    // divide by 256 then scaler plus one
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_cnt   <= 8'h00;
            scale_cnt <= 8'h00;
            tick      <= 1'b0;
        end else if (clear) begin
            pre_cnt   <= 8'h00;
            scale_cnt <= 8'h00;
            tick      <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (pre_cnt == 8'(PRESCALE - 1)) begin
                pre_cnt <= 8'h00;
                if (scale_cnt == scaler) begin
                    scale_cnt <= 8'h00;
                    tick      <= 1'b1;
                end else begin
                    scale_cnt <= scale_cnt + 8'h01;
                end
            end else begin
                pre_cnt <= pre_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/efc_cpu_model.sv
// CPU-side model of the flash command controller's register port.
// Assumes the controller samples strobes at the rising edge of core_clk.
`default_nettype none
module efc_cpu_model (
    input  wire logic        core_clk,
    input  wire logic        cpu_stall,
    input  wire logic [7:0]  reg_rdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_addr,
    output logic      [7:0]  reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 16'h0000;
        reg_wdata = 8'h00;
    end

    // Released bus shows inverted values so stale data never looks valid
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask

    // idle while stalled, caller reads status after
    task automatic run(input logic [7:0] c, output int busy);
        int i;
        busy = 0;
        wr(efc_pkg::CMD_REG_ADDR, c);
        for (i = 0; i < 40000; i++) begin
            @(posedge core_clk);
            #1;
            if (cpu_stall === 1'b1) begin
                busy++;
            end else if (busy > 0 || i > 3) begin
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: sim/embedded_flash_command_controller_tb.sv
// Self-checking bench for the flash command controller.
// Assumes scaler 0 or 1 so that timed runs stay short.
`default_nettype none
module embedded_flash_command_controller_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        cpu_stall;
    int          failures = 0;
    int          n_tests  = 0;
    logic [7:0]  mem [int];
    logic [15:0] a1;
    logic [15:0] a2;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [7:0]  d3;
    logic [4:0]  bad [4] = '{5'h00, 5'h03, 5'h12, 5'h1F};
    int          busy;

    efc_controller efc_controller_i (
        .core_clk (core_clk),
        .rst      (rst),
        .reg_wr   (reg_wr),
        .reg_rd   (reg_rd),
        .reg_addr (reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .cpu_stall(cpu_stall)
    );

    efc_cpu_model efc_cpu_model_i (
        .core_clk (core_clk),
        .cpu_stall(cpu_stall),
        .reg_rdata(reg_rdata),
        .reg_wr   (reg_wr),
        .reg_rd   (reg_rd),
        .reg_addr (reg_addr),
        .reg_wdata(reg_wdata)
    );

    always #50 core_clk = ~core_clk;

    task automatic end_of_test;
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Tick phase at start is fixed by the time base clear while idle; callers set the slack below
    task automatic chk_len(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic w(input logic [15:0] a, input logic [7:0] d);
        efc_cpu_model_i.wr(a, d);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        efc_cpu_model_i.rd(a, v);
        chk_byte(v, exp);
    endtask

    task automatic load(input logic [15:0] a, input logic [7:0] d);
        w(efc_pkg::ADDRH_REG_ADDR, a[15:8]);
        w(efc_pkg::ADDRL_REG_ADDR, a[7:0]);
        w(efc_pkg::DATA_REG_ADDR, d);
    endtask

    // Status read: bit 6 is unused, so it is masked
    task automatic st(input logic [4:0] code, input logic f);
        logic [7:0] v;
        efc_cpu_model_i.rd(efc_pkg::CMD_REG_ADDR, v);
        chk_byte(v & 8'hBF, {1'b1, 1'b0, f, code});
    endtask

    task automatic refuse(input logic [15:0] a, input logic [4:0] code);
        load(a, 8'hC3);
        efc_cpu_model_i.run({3'b000, code}, busy);
        chk_len(busy, 0, 0);
        st(code, 1'b1);
    endtask

    task automatic wr_cmd(input logic [15:0] a, input logic [7:0] d, input logic [4:0] code,
                          input logic [2:0] cyc, input int n);
        load(a, d);
        efc_cpu_model_i.run({cyc, code}, busy);
        chk_len(busy, n - n / 55 * 5, n + 8);
        st(code, 1'b0);
    endtask

    task automatic rd_cmd(input logic [15:0] a, input logic [4:0] code, input logic [7:0] exp);
        load(a, ~exp);
        efc_cpu_model_i.run({3'b000, code}, busy);
        st(code, 1'b0);
        rd_chk(efc_pkg::DATA_REG_ADDR, exp);
    endtask

    initial begin
        repeat (90000) @(posedge core_clk);
        failures++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h7d89));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(efc_pkg::CMD_REG_ADDR, 8'h80);
        rd_chk(efc_pkg::PLOW_REG_ADDR, 8'hFF);
        rd_chk(efc_pkg::PHIGH_REG_ADDR, 8'h00);
        rd_chk(efc_pkg::SCALE_REG_ADDR, efc_pkg::SCALE_RESET);
        refuse(16'h0100, efc_pkg::CMD_MAIN_WRITE);
        refuse(16'h4000, efc_pkg::CMD_MAIN_ERASE);
        w(efc_pkg::PLOW_REG_ADDR, 8'h01);
        w(efc_pkg::PHIGH_REG_ADDR, 8'h7E);
        // Fastest time base the sim clock allows, nearest to the intended rate
        w(efc_pkg::SCALE_REG_ADDR, 8'h00);
        refuse(16'h00FF, efc_pkg::CMD_MAIN_WRITE);
        refuse(16'h7F00, efc_pkg::CMD_MAIN_WRITE);
        a1 = 16'h0100 + 16'($urandom % 32'h7E00);
        // Second target stays inside the open granules 01..7E and differs from the first
        a2 = 16'h0100 + 16'((int'(a1) - 256 + 16128) % 32256);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        d3 = 8'($urandom);
        wr_cmd(a1, d1, efc_pkg::CMD_MAIN_WRITE, 3'd0, 55 * 256);
        mem[a1] = d1;
        // Data written while busy must be dropped
        w(efc_pkg::SCALE_REG_ADDR, 8'h01);
        load(a2, d2);
        fork
            efc_cpu_model_i.run({3'd1, efc_pkg::CMD_MAIN_WRITE}, busy);
            begin
                repeat (8) @(posedge core_clk);
                w(efc_pkg::DATA_REG_ADDR, ~d2);
            end
        join
        chk_len(busy, 60 * 512 - 512, 60 * 512 + 8);
        rd_chk(efc_pkg::DATA_REG_ADDR, d2);
        mem[a2] = d2;
        w(efc_pkg::SCALE_REG_ADDR, 8'h00);
        foreach (mem[k]) rd_cmd(16'(k), efc_pkg::CMD_MAIN_READ, mem[k]);
        wr_cmd(16'h0040, d3, efc_pkg::CMD_INFO_WRITE, 3'd7, 89 * 256);
        rd_cmd(16'h0040, efc_pkg::CMD_INFO_READ, d3);
        refuse(16'h003F, efc_pkg::CMD_INFO_WRITE);
        refuse(16'h8000, efc_pkg::CMD_MAIN_READ);
        foreach (bad[i]) refuse(16'h0200, bad[i]);
        st(5'h1F, 1'b1);
        rd_cmd(a1, efc_pkg::CMD_MAIN_READ, d1);
        end_of_test();
    end
endmodule
`default_nettype wire
